// File: src/liu_direct_control_decoder.sv
// direct-control decoder for a quad line interface: pins to modes, alarms and line symbols
// assumes pclk is the free-running reference clock; pins are asynchronous to it
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "liu_map.svh"
module liu_direct_control_decoder import liu_pkg::*; #(
  parameter int NCH = `LIU_NCH,
  parameter int SYM_DIV = `LIU_SYM_DIV,
  parameter int LOS_MS_CYCLES = `LIU_ANALOG_SIGNAL_LOSS_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] eq_select_a,
  input wire logic [NCH-1:0] eq_select_b,
  input wire logic [NCH-1:0] eq_select_c,
  input wire logic [NCH-1:0] tx_alarm_insert,
  input wire logic [NCH-1:0] remote_loop_n,
  input wire logic [NCH-1:0] channel_powerdown,
  input wire logic [NCH-1:0] tx_pos_rail,
  input wire logic [NCH-1:0] tx_neg_rail,
  input wire logic [NCH-1:0] rx_line_pos,
  input wire logic [NCH-1:0] rx_line_neg,
  input wire logic [NCH-1:0] rx_signal_present,
  input wire logic rx_alarm_select,
  input wire logic loss_shutdown_control,
  input wire logic loss_timer_select,
  input wire logic tx_attenuator_select,
  input wire logic rx_attenuator_select,
  input wire logic chip_mode_select,
  input wire logic attenuator_bandwidth_select,
  input wire logic polarity_select,
  input wire logic retime_edge_select,
  input wire logic rail_mode_select,
  input wire logic hw_reset_n,
  input wire logic output_disable_n,
  output logic [NCH-1:0] line_tx_pos,
  output logic [NCH-1:0] line_tx_neg,
  output logic [NCH-1:0] rx_pos_rail,
  output logic [NCH-1:0] rx_neg_rail,
  output logic [NCH-1:0] analog_signal_loss_n,
  output logic [NCH-1:0] digital_signal_loss_n,
  output logic [NCH-1:0] channel_standby,
  output logic [NCH-1:0] cept_mode,
  output logic [3*NCH-1:0] eq_setting,
  output logic [NCH-1:0] zero_sub_enable,
  output logic [NCH-1:0] ja_low_bw,
  output logic ja_tx_enable,
  output logic ja_rx_enable,
  output logic micro_mode,
  output logic rx_retime_rising,
  output logic dual_rail_mode,
  output logic out_enable_n
);

  localparam int SYM_W = $clog2(SYM_DIV);
  localparam int LOS_W = $clog2(LOS_MS_CYCLES + 1);
  localparam int SYNC_W = 11 * NCH + 12;

  // every pin crosses two flops before any decode sees it
  logic [SYNC_W-1:0] sync_bus;
  logic [NCH-1:0] s_eqa, s_eqb, s_eqc, s_ais, s_rloop_n, s_pwr;
  logic [NCH-1:0] s_txp, s_txn, s_rxp, s_rxn, s_sigp;
  logic s_rxais, s_loss_shutdown_control, s_timer, s_jat, s_jar, s_chip_mode_select, s_bw, s_pol, s_edge, s_rail;
  logic s_hw_rst_n, s_oe_n;

  cfg_sync #(.WIDTH(SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({eq_select_a, eq_select_b, eq_select_c, tx_alarm_insert, remote_loop_n,
      channel_powerdown, tx_pos_rail, tx_neg_rail, rx_line_pos, rx_line_neg,
      rx_signal_present, rx_alarm_select, loss_shutdown_control, loss_timer_select,
      tx_attenuator_select, rx_attenuator_select, chip_mode_select,
      attenuator_bandwidth_select, polarity_select, retime_edge_select, rail_mode_select,
      hw_reset_n, output_disable_n}),
    .sync_out(sync_bus)
  );

  assign {s_eqa, s_eqb, s_eqc, s_ais, s_rloop_n, s_pwr, s_txp, s_txn, s_rxp, s_rxn, s_sigp,
    s_rxais, s_loss_shutdown_control, s_timer, s_jat, s_jar, s_chip_mode_select, s_bw, s_pol, s_edge, s_rail,
    s_hw_rst_n, s_oe_n} = sync_bus;

  // apb slave, chip-wide mode state and per-channel mode state
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic soft_rst_reg, soft_rst_next;
  logic [SYM_W-1:0] sym_cnt_reg, sym_cnt_next;
  logic sym_tick_reg, sym_tick_next;
  logic [3*NCH-1:0] eq_reg, eq_next;
  logic [NCH-1:0] cept_reg, cept_next, bw_reg, bw_next, zsub_reg, zsub_next;
  logic [NCH-1:0] standby_reg, standby_next;
  logic ja_tx_reg, ja_tx_next, ja_rx_reg, ja_rx_next, micro_reg, micro_next;
  logic edge_reg, edge_next, dual_reg, dual_next, oe_n_reg, oe_n_next;
  logic setup, access, mapped, run;
  shutdown_mode_e shut_mode;

  // datapath runs only while neither the pin nor the soft reset holds it
  assign run = s_hw_rst_n & ~soft_rst_reg;

  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & pready_reg;
    mapped = (paddr == `LIU_REG_CTRL) || (paddr == `LIU_REG_STATUS);
    // data and error are taken at setup so they stand through the access phase
    pready_next = setup;
    pslverr_next = setup & ~mapped;
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0;
      if (!pwrite && paddr == `LIU_REG_CTRL) begin
        prdata_next[`LIU_CTRL_SOFT_RST] = soft_rst_reg;
      end else if (!pwrite && paddr == `LIU_REG_STATUS) begin
        prdata_next = {12'h000, dual_reg, micro_reg, ja_rx_reg, ja_tx_reg, cept_reg,
          standby_reg, digital_signal_loss_n, analog_signal_loss_n};
      end
    end
    soft_rst_next = soft_rst_reg;
    if (access && pwrite && !pslverr_reg && paddr == `LIU_REG_CTRL) begin
      soft_rst_next = pwdata[`LIU_CTRL_SOFT_RST];
    end
    // symbol strobe from the reference clock
    sym_tick_next = (sym_cnt_reg == SYM_W'(SYM_DIV - 1));
    sym_cnt_next = sym_tick_next ? '0 : sym_cnt_reg + 1'b1;
    for (int i = 0; i < NCH; i++) begin
      eq_next[3*i +: 3] = {s_eqc[i], s_eqb[i], s_eqa[i]};
      cept_next[i] = ({s_eqc[i], s_eqb[i], s_eqa[i]} >= `LIU_EQ_CEPT_MIN);
    end
    bw_next = {NCH{s_bw}} & cept_next;
    zsub_next = {NCH{~s_rail}} & s_txn;
    standby_next = s_pwr;
    ja_tx_next = s_jat & ~s_jar;
    ja_rx_next = s_jar & ~s_jat;
    micro_next = s_chip_mode_select;
    edge_next = s_edge;
    dual_next = s_rail;
    oe_n_next = ~s_oe_n;
    // alarm select dominates; shutdown control alone only squelches
    if (s_rxais) begin
      shut_mode = SHUT_AIS;
    end else if (s_loss_shutdown_control) begin
      shut_mode = SHUT_SQUELCH;
    end else begin
      shut_mode = SHUT_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      sym_cnt_reg <= '0;
      sym_tick_reg <= 1'b0;
      eq_reg <= '0;
      cept_reg <= '0;
      bw_reg <= '0;
      zsub_reg <= '0;
      standby_reg <= '0;
      ja_tx_reg <= 1'b0;
      ja_rx_reg <= 1'b0;
      micro_reg <= 1'b0;
      edge_reg <= 1'b0;
      dual_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      soft_rst_reg <= soft_rst_next;
      sym_cnt_reg <= sym_cnt_next;
      sym_tick_reg <= sym_tick_next;
      eq_reg <= eq_next;
      cept_reg <= cept_next;
      bw_reg <= bw_next;
      zsub_reg <= zsub_next;
      standby_reg <= standby_next;
      ja_tx_reg <= ja_tx_next;
      ja_rx_reg <= ja_rx_next;
      micro_reg <= micro_next;
      edge_reg <= edge_next;
      dual_reg <= dual_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign eq_setting = eq_reg;
  assign cept_mode = cept_reg;
  assign ja_low_bw = bw_reg;
  assign zero_sub_enable = zsub_reg;
  assign channel_standby = standby_reg;
  assign ja_tx_enable = ja_tx_reg;
  assign ja_rx_enable = ja_rx_reg;
  assign micro_mode = micro_reg;
  assign rx_retime_rising = edge_reg;
  assign dual_rail_mode = dual_reg;
  assign out_enable_n = oe_n_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ja_exclusive_a: assert property (!(ja_tx_enable && ja_rx_enable))
    else $error("attenuator placed in both paths");
  ja_tx_path_a: assert property (s_jat && !s_jar |=> ja_tx_enable)
    else $error("transmit attenuator not enabled");
  ja_rx_path_a: assert property (s_jar && !s_jat |=> ja_rx_enable && !ja_tx_enable)
    else $error("receive attenuator not enabled");
  chip_mode_a: assert property (s_chip_mode_select != $past(s_chip_mode_select) |=> micro_mode == $past(s_chip_mode_select))
    else $error("chip mode not followed");
  hiz_follow_a: assert property (!s_oe_n |=> out_enable_n)
    else $error("outputs driven while disabled");
  low_bw_a: assert property (ja_low_bw != 0 |-> $past(s_bw) && (ja_low_bw & ~cept_mode) == 0)
    else $error("low bandwidth outside cept");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  apb_write_cov: cover property (psel && penable && pready && pwrite);

  // per-channel loss detection and line symbol generation
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [LOS_W-1:0] los_cnt_reg, los_cnt_next, los_limit;
    logic [7:0] zero_cnt_reg, zero_cnt_next, zero_limit;
    logic analog_signal_loss_n_reg, analog_signal_loss_n_next, digital_signal_loss_n_reg, digital_signal_loss_n_next;
    logic ami_neg_reg, ami_neg_next, last_neg_reg, last_neg_next, seen_reg, seen_next;
    logic txp_reg, txp_next, txn_reg, txn_next, rxo_p_reg, rxo_p_next, rxo_n_reg, rxo_n_next;
    logic los_step, mark, bipolar_violation_flag, loss, rd_p, rd_n, td_p, td_n, tx_mark;
    tx_src_e tx_src;

    always_comb begin
      los_cnt_next = los_cnt_reg;
      zero_cnt_next = zero_cnt_reg;
      analog_signal_loss_n_next = analog_signal_loss_n_reg;
      digital_signal_loss_n_next = digital_signal_loss_n_reg;
      ami_neg_next = ami_neg_reg;
      last_neg_next = last_neg_reg;
      seen_next = seen_reg;
      txp_next = txp_reg;
      txn_next = txn_reg;
      rxo_p_next = rxo_p_reg;
      rxo_n_next = rxo_n_reg;
      // one extra strobe covers the partial first symbol period
      los_limit = s_timer ? LOS_W'(`LIU_ANALOG_SIGNAL_LOSS_SYM_MIN + 1) : LOS_W'(LOS_MS_CYCLES);
      los_step = s_timer ? sym_tick_reg : 1'b1;
      zero_limit = cept_reg[ch] ? 8'(`LIU_DIGITAL_SIGNAL_LOSS_CEPT_ZEROS) : 8'(`LIU_DIGITAL_SIGNAL_LOSS_DS1_ZEROS);
      mark = s_rxp[ch] | s_rxn[ch];
      bipolar_violation_flag = mark & seen_reg & (s_rxn[ch] == last_neg_reg);
      loss = ~analog_signal_loss_n_reg | ~digital_signal_loss_n_reg;
      // alarm insertion is checked before loopback on purpose
      if (s_ais[ch]) begin
        tx_src = TX_SRC_AIS;
      end else if (!s_rloop_n[ch]) begin
        tx_src = TX_SRC_LOOP;
      end else begin
        tx_src = TX_SRC_DATA;
      end
      td_p = s_txp[ch] ^ ~s_pol;
      td_n = s_txn[ch] ^ ~s_pol;
      tx_mark = (tx_src == TX_SRC_AIS) | td_p;
      rd_p = s_rail ? s_rxp[ch] : mark;
      rd_n = s_rail ? s_rxn[ch] : bipolar_violation_flag;
      if (loss && shut_mode == SHUT_SQUELCH) begin
        rd_p = 1'b0;
        rd_n = 1'b0;
      end else if (loss && shut_mode == SHUT_AIS) begin
        rd_p = 1'b1;
        rd_n = 1'b0;
      end
      if (!run || standby_reg[ch]) begin
        // held state also stops all line activity, which is the low-power standby
        los_cnt_next = '0;
        zero_cnt_next = '0;
        analog_signal_loss_n_next = 1'b1;
        digital_signal_loss_n_next = 1'b1;
        ami_neg_next = 1'b0;
        seen_next = 1'b0;
        txp_next = 1'b0;
        txn_next = 1'b0;
        rxo_p_next = 1'b0;
        rxo_n_next = 1'b0;
      end else begin
        if (s_sigp[ch]) begin
          los_cnt_next = '0;
          analog_signal_loss_n_next = 1'b1;
        end else if (los_step && los_cnt_reg >= los_limit - 1'b1) begin
          analog_signal_loss_n_next = 1'b0;
        end else if (los_step) begin
          los_cnt_next = los_cnt_reg + 1'b1;
        end
        if (sym_tick_reg) begin
          if (mark) begin
            zero_cnt_next = '0;
            digital_signal_loss_n_next = 1'b1;
            last_neg_next = s_rxn[ch];
            seen_next = 1'b1;
          end else if (zero_cnt_reg >= zero_limit - 1'b1) begin
            digital_signal_loss_n_next = 1'b0;
          end else begin
            zero_cnt_next = zero_cnt_reg + 1'b1;
          end
          rxo_p_next = rd_p ^ ~s_pol;
          rxo_n_next = rd_n ^ ~s_pol;
          unique case (tx_src)
            TX_SRC_LOOP: begin
              txp_next = s_rxp[ch];
              txn_next = s_rxn[ch];
            end
            TX_SRC_DATA, TX_SRC_AIS: begin
              if (s_rail && tx_src == TX_SRC_DATA) begin
                txp_next = td_p;
                txn_next = td_n & ~td_p;
              end else begin
                // alternate mark inversion; all ones when alarm is inserted
                txp_next = tx_mark & ~ami_neg_reg;
                txn_next = tx_mark & ami_neg_reg;
                ami_neg_next = ami_neg_reg ^ tx_mark;
              end
            end
          endcase
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        los_cnt_reg <= '0;
        zero_cnt_reg <= '0;
        analog_signal_loss_n_reg <= 1'b1;
        digital_signal_loss_n_reg <= 1'b1;
        ami_neg_reg <= 1'b0;
        last_neg_reg <= 1'b0;
        seen_reg <= 1'b0;
        txp_reg <= 1'b0;
        txn_reg <= 1'b0;
        rxo_p_reg <= 1'b0;
        rxo_n_reg <= 1'b0;
      end else begin
        los_cnt_reg <= los_cnt_next;
        zero_cnt_reg <= zero_cnt_next;
        analog_signal_loss_n_reg <= analog_signal_loss_n_next;
        digital_signal_loss_n_reg <= digital_signal_loss_n_next;
        ami_neg_reg <= ami_neg_next;
        last_neg_reg <= last_neg_next;
        seen_reg <= seen_next;
        txp_reg <= txp_next;
        txn_reg <= txn_next;
        rxo_p_reg <= rxo_p_next;
        rxo_n_reg <= rxo_n_next;
      end
    end

    assign line_tx_pos[ch] = txp_reg;
    assign line_tx_neg[ch] = txn_reg;
    assign rx_pos_rail[ch] = rxo_p_reg;
    assign rx_neg_rail[ch] = rxo_n_reg;
    assign analog_signal_loss_n[ch] = analog_signal_loss_n_reg;
    assign digital_signal_loss_n[ch] = digital_signal_loss_n_reg;

    analog_signal_loss_slow_a: assert property ($fell(analog_signal_loss_n_reg) && !s_timer |->
      $past(los_cnt_reg) == LOS_W'(LOS_MS_CYCLES - 1) && !$past(s_sigp[ch]))
      else $error("slow analog loss declared at wrong count");
    analog_signal_loss_fast_a: assert property ($fell(analog_signal_loss_n_reg) && s_timer |-> $past(sym_tick_reg))
      else $error("fast analog loss not on a symbol strobe");
    ais_ones_a: assert property (run && !standby_reg[ch] && s_ais[ch] && sym_tick_reg
      |=> txp_reg != txn_reg)
      else $error("alarm insert did not send a mark");
    standby_quiet_a: assert property (standby_reg[ch] && $past(standby_reg[ch]) |->
      !txp_reg && !txn_reg && analog_signal_loss_n_reg)
      else $error("standby channel still active");
    reset_clear_a: assert property (!run |=> digital_signal_loss_n_reg && analog_signal_loss_n_reg && !txp_reg)
      else $error("hardware reset did not clear channel");
    ais_cov: cover property (s_ais[ch] && !s_rloop_n[ch] && sym_tick_reg);
    analog_signal_loss_cov: cover property ($fell(analog_signal_loss_n_reg));
    digital_signal_loss_cov: cover property ($fell(digital_signal_loss_n_reg));
  end

endmodule // liu_direct_control_decoder

// File: common/liu_map.svh
// constant map for the direct-control line interface decoder: offsets, counts, timings
// assumes a 100 MHz pclk that doubles as the free-running reference clock
`ifndef LIU_MAP_SVH
`define LIU_MAP_SVH

`define LIU_NCH 4
`define LIU_SYNC_BITS 56
`define LIU_CLK_PERIOD_NS 10
// analog loss window with the slow timer, in ns
`define LIU_ANALOG_SIGNAL_LOSS_MIN_NS 1000000
`define LIU_ANALOG_SIGNAL_LOSS_MAX_NS 2600000
`define LIU_ANALOG_SIGNAL_LOSS_MS_CYCLES ((`LIU_ANALOG_SIGNAL_LOSS_MIN_NS + `LIU_CLK_PERIOD_NS - 1) / `LIU_CLK_PERIOD_NS)
// analog loss window with the fast timer, in bit symbol periods
`define LIU_ANALOG_SIGNAL_LOSS_SYM_MIN 10
`define LIU_ANALOG_SIGNAL_LOSS_SYM_MAX 255
// consecutive zeros that declare digital loss
`define LIU_DIGITAL_SIGNAL_LOSS_DS1_ZEROS 100
`define LIU_DIGITAL_SIGNAL_LOSS_CEPT_ZEROS 255
// reference clock cycles per bit symbol
`define LIU_SYM_DIV 48
// equalizer codes at or above this value select CEPT operation
`define LIU_EQ_CEPT_MIN 3'h4
// apb register byte offsets and fields
`define LIU_REG_CTRL 8'h00
`define LIU_REG_STATUS 8'h04
`define LIU_CTRL_SOFT_RST 0

`endif

// File: common/liu_pkg.sv
// types shared by the direct-control line interface decoder
// assumes the constant map in liu_map.svh for all figures
package liu_pkg;

  // receiver behaviour while a loss of signal is present
  typedef enum logic [1:0] {SHUT_NONE, SHUT_SQUELCH, SHUT_AIS} shutdown_mode_e;

  // source of the transmit line symbols
  typedef enum logic [1:0] {TX_SRC_DATA, TX_SRC_LOOP, TX_SRC_AIS} tx_src_e;

  typedef logic [2:0] eq_code_t;

endpackage

// File: src/cfg_sync.sv
// two-flop synchroniser for the static configuration and line pins
// assumes every bit is a slow level; no bus coherence between bits is promised
`timescale 1ns/1ns
module cfg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  // first stage feeds only the second stage
  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;

endmodule // cfg_sync

// File: dv/line_source.sv
// line receiver stand-in: slicer marks and an amplitude-present level per channel
// assumes one symbol lasts SYM_DIV reference cycles and marks alternate as in ami
`timescale 1ns/1ns
module line_source #(
  parameter int SYM_DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic marks_on,
  input wire logic sig_on,
  output logic [3:0] rx_line_pos,
  output logic [3:0] rx_line_neg,
  output logic [3:0] rx_signal_present
);
  int cnt;
  logic phase;

  // a mark every symbol keeps digital loss quiet; marks off gives a zero run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      phase <= 1'b0;
      rx_line_pos <= 4'h0;
      rx_line_neg <= 4'h0;
    end else if (cnt == SYM_DIV - 1) begin
      cnt <= 0;
      phase <= ~phase;
      rx_line_pos <= (marks_on && !phase) ? 4'hF : 4'h0;
      rx_line_neg <= (marks_on && phase) ? 4'hF : 4'h0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // amplitude detector level, shared by all channels to keep the bench small
  assign rx_signal_present = {4{sig_on}};
endmodule // line_source

// File: dv/testbench.sv
// self-checking bench for the direct-control decoder: apb tasks and pin scenarios
// assumes line_source as the line side; long counts shortened through parameters
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench import liu_pkg::*;;
  localparam int SD = 4;
  localparam int LM = 50;
  int error_cnt = 0, compares = 0, n, m, k;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, marks_on = 1'b1, sig_on = 1'b1;
  logic [3:0] eq_select_a = 4'h0, eq_select_b = 4'h0, eq_select_c = 4'h0;
  logic [3:0] tx_alarm_insert = 4'h0, remote_loop_n = 4'hF, channel_powerdown = 4'h0;
  logic [3:0] tx_pos_rail = 4'h0, tx_neg_rail = 4'h0, rx_line_pos, rx_line_neg;
  logic [3:0] rx_signal_present, line_tx_pos, line_tx_neg, rx_pos_rail, rx_neg_rail;
  logic [3:0] analog_signal_loss_n, digital_signal_loss_n, channel_standby, cept_mode;
  logic [3:0] zero_sub_enable, ja_low_bw;
  logic [11:0] eq_setting;
  logic rx_alarm_select = 1'b0, loss_shutdown_control = 1'b0, loss_timer_select = 1'b0;
  logic tx_attenuator_select = 1'b0, rx_attenuator_select = 1'b0, chip_mode_select = 1'b0;
  logic attenuator_bandwidth_select = 1'b0, polarity_select = 1'b1;
  logic retime_edge_select = 1'b0, rail_mode_select = 1'b0;
  logic hw_reset_n = 1'b0, output_disable_n = 1'b1;
  logic ja_tx_enable, ja_rx_enable, micro_mode, rx_retime_rising, dual_rail_mode;
  logic out_enable_n;

  // 100 MHz free-running reference clock
  always #5 pclk = ~pclk;

  liu_direct_control_decoder #(.SYM_DIV(SD), .LOS_MS_CYCLES(LM)) u_liu_direct_control_decoder (.*);

  line_source #(.SYM_DIV(SD)) u_line_source (.*);

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed here; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // cuts a hang short; the whole sequence needs under 1500 cycles
  initial begin
    cyc(5000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    cyc(5);
    presetn <= 1'b1;
    cyc(LM);
    hw_reset_n <= 1'b1;
    cyc(150);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rd, 32'h000000FF)
    @(posedge pclk);
    eq_select_c <= 4'h8;
    channel_powerdown <= 4'h4;
    tx_attenuator_select <= 1'b1;
    chip_mode_select <= 1'b1;
    rail_mode_select <= 1'b1;
    attenuator_bandwidth_select <= 1'b1;
    retime_edge_select <= 1'b1;
    cyc(6);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rd, 32'h000D84FF)
    `CHK({cept_mode, channel_standby}, 8'h84)
    `CHK(eq_setting[11:9], 3'h4)
    `CHK(ja_low_bw, 4'h8)
    `CHK(rx_retime_rising, 1'b1)
    // every pairing of the two attenuator selects
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      tx_attenuator_select <= i[0];
      rx_attenuator_select <= i[1];
      cyc(6);
      `CHK(ja_tx_enable, i[0] & ~i[1])
      `CHK(ja_rx_enable, i[1] & ~i[0])
    end
    @(posedge pclk);
    rail_mode_select <= 1'b0;
    chip_mode_select <= 1'b0;
    channel_powerdown <= 4'h0;
    eq_select_c <= 4'h0;
    tx_neg_rail <= 4'h2;
    output_disable_n <= 1'b0;
    cyc(6);
    `CHK(zero_sub_enable, 4'h2)
    `CHK({micro_mode, dual_rail_mode}, 2'b00)
    `CHK(out_enable_n, 1'b1)
    @(posedge pclk);
    output_disable_n <= 1'b1;
    marks_on <= 1'b0;
    remote_loop_n <= 4'hE;
    tx_alarm_insert <= 4'h1;
    cyc(10);
    `CHK(out_enable_n, 1'b0)
    n = 0;
    m = 0;
    k = 0;
    // looped data is all zeros here, so only the alarm can put marks out
    repeat (16 * SD) begin
      @(posedge pclk);
      #1;
      n += int'(line_tx_pos[0] ^ line_tx_neg[0]);
      m += int'(line_tx_pos[0]);
      k += int'((line_tx_pos[1] | line_tx_neg[1]) !== 1'b0);
    end
    `CHK(n, 16 * SD)
    `CHK(m, 8 * SD)
    `CHK(k, 0)
    // a run of 100 zero symbols is digital loss; look well before and after it
    cyc(300);
    `CHK(digital_signal_loss_n, 4'hF)
    cyc(60);
    `CHK(digital_signal_loss_n, 4'h0)
    @(posedge pclk);
    tx_alarm_insert <= 4'h0;
    remote_loop_n <= 4'hF;
    marks_on <= 1'b1;
    sig_on <= 1'b0;
    rx_alarm_select <= 1'b1;
    cyc(45);
    `CHK(analog_signal_loss_n, 4'hF)
    cyc(90);
    `CHK(analog_signal_loss_n, 4'h0)
    `CHK(rx_pos_rail, 4'hF)
    @(posedge pclk);
    rx_alarm_select <= 1'b0;
    loss_shutdown_control <= 1'b1;
    cyc(2 * SD + 6);
    `CHK(rx_pos_rail, 4'h0)
    `CHK(rx_neg_rail, 4'h0)
    // active-low data turns the squelched zeros into ones on both rails
    @(posedge pclk);
    polarity_select <= 1'b0;
    cyc(2 * SD + 6);
    `CHK({rx_pos_rail, rx_neg_rail}, 8'hFF)
    @(posedge pclk);
    polarity_select <= 1'b1;
    hw_reset_n <= 1'b0;
    cyc(LM);
    `CHK(analog_signal_loss_n, 4'hF)
    @(posedge pclk);
    hw_reset_n <= 1'b1;
    loss_timer_select <= 1'b1;
    cyc(38);
    `CHK(analog_signal_loss_n, 4'hF)
    cyc(62);
    `CHK(analog_signal_loss_n, 4'h0)
    // soft reset clears channel state like the pin; stray addresses are refused
    apb(8'h00, 1'b1, 32'h1);
    cyc(5);
    `CHK(analog_signal_loss_n, 4'hF)
    apb(8'h00, 1'b0, 32'h0);
    `CHK(rd, 32'h1)
    apb(8'h00, 1'b1, 32'h0);
    apb(8'h08, 1'b0, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    print_verdict();
  end
endmodule // testbench
